// >>> hdl/cpf_top.sv
`timescale 1ns/1ps
module cpf_top #(
  parameter bit LATCH_VARIANT = 1'b0,
  parameter bit POWERDOWN_VARIANT = 1'b1,
  parameter int OC_DET = cpf_pkg::OC_DET_CYC,
  parameter int OC_REL = cpf_pkg::OC_REL_CYC,
  parameter int OD_DET = cpf_pkg::OD_DET_CYC,
  parameter int OD_REL = cpf_pkg::OD_REL_CYC,
  parameter int DOC_DET = cpf_pkg::DOC_CYC,
  parameter int SC_DET = cpf_pkg::SC_CYC,
  parameter int COC_DET = cpf_pkg::COC_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire cpf_pkg::cpf_cmp_s cmp_in,
  output cpf_pkg::cpf_out_s ctl_out,
  output cpf_pkg::cpf_state_e state_out
);
  localparam int W = cpf_pkg::TIMER_W;

  cpf_pkg::cpf_cmp_s sync_a;
  cpf_pkg::cpf_cmp_s cmp;
  always_ff @(posedge clock) begin
    sync_a <= cmp_in;
    cmp <= sync_a;
  end

  cpf_pkg::cpf_state_e state;
  cpf_pkg::cpf_state_e next_state;

  // test mode via current-sense at supply
  wire test_mode = cmp.sense_at_supply;
  wire [W-1:0] oc_det_lim = test_mode ? W'(OC_DET / cpf_pkg::TEST_DIVIDE) : W'(OC_DET);
  wire [W-1:0] od_det_lim = test_mode ? W'(OD_DET / cpf_pkg::TEST_DIVIDE) : W'(OD_DET);

  // sign selects checks; test mode masks current checks
  wire charging = cmp.below_charge_overcurrent && !test_mode;
  wire dsg_oc = cmp.above_discharge_overcurrent && !cmp.above_short_circuit && !test_mode;
  wire dsg_sc = cmp.above_short_circuit && !test_mode;
  wire charger_on = !cmp.sense_above_half;
  wire load_on = cmp.sense_above_quarter;
  wire in_normal = state == cpf_pkg::CPF_NORMAL;

  wire below_hys = !cmp.above_overcharge_less_hys;
  wire oc_release = LATCH_VARIANT ? (below_hys && load_on)
    : ((!cmp.above_overcharge && load_on) || below_hys);

  // Qualifying conditions for each timer
  wire c_oc_det = in_normal && cmp.above_overcharge;
  wire c_oc_rel = state == cpf_pkg::CPF_OVERCHARGE && oc_release;
  wire c_od_det = in_normal && cmp.below_overdischarge;
  wire c_od_rel = state == cpf_pkg::CPF_OVERDISCHARGE && cmp.above_overdischarge_release
    && charger_on;
  wire c_doc = in_normal && dsg_oc;
  wire c_sc = in_normal && dsg_sc;
  wire c_coc = in_normal && charging;

  logic [W-1:0] t_oc_det, t_oc_rel, t_od_det, t_od_rel, t_doc, t_sc, t_coc;
  wire [W-1:0] next_oc_det = c_oc_det ? t_oc_det + 1'b1 : '0;
  wire [W-1:0] next_oc_rel = c_oc_rel ? t_oc_rel + 1'b1 : '0;
  wire [W-1:0] next_od_det = c_od_det ? t_od_det + 1'b1 : '0;
  wire [W-1:0] next_od_rel = c_od_rel ? t_od_rel + 1'b1 : '0;
  wire [W-1:0] next_doc = c_doc ? t_doc + 1'b1 : '0;
  wire [W-1:0] next_sc = c_sc ? t_sc + 1'b1 : '0;
  wire [W-1:0] next_coc = c_coc ? t_coc + 1'b1 : '0;

  wire e_oc_det = c_oc_det && t_oc_det >= oc_det_lim;
  wire e_oc_rel = c_oc_rel && t_oc_rel >= W'(OC_REL);
  wire e_od_det = c_od_det && t_od_det >= od_det_lim;
  wire e_od_rel = c_od_rel && t_od_rel >= W'(OD_REL);
  wire e_doc = c_doc && t_doc >= W'(DOC_DET);
  wire e_sc = c_sc && t_sc >= W'(SC_DET);
  wire e_coc = c_coc && t_coc >= W'(COC_DET);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      t_oc_det <= '0;
      t_oc_rel <= '0;
      t_od_det <= '0;
      t_od_rel <= '0;
      t_doc <= '0;
      t_sc <= '0;
      t_coc <= '0;
    end else begin
      t_oc_det <= next_oc_det;
      t_oc_rel <= next_oc_rel;
      t_od_det <= next_od_det;
      t_od_rel <= next_od_rel;
      t_doc <= next_doc;
      t_sc <= next_sc;
      t_coc <= next_coc;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      cpf_pkg::CPF_NORMAL: begin
        if (e_sc) next_state = cpf_pkg::CPF_DSG_OVERCURRENT;
        else if (e_doc) next_state = cpf_pkg::CPF_DSG_OVERCURRENT;
        else if (e_od_det) next_state = cpf_pkg::CPF_OVERDISCHARGE;
        else if (e_oc_det) next_state = cpf_pkg::CPF_OVERCHARGE;
        else if (e_coc) next_state = cpf_pkg::CPF_CHG_OVERCURRENT;
      end
      cpf_pkg::CPF_OVERCHARGE: begin
        if (e_oc_rel) next_state = cpf_pkg::CPF_NORMAL;
      end
      cpf_pkg::CPF_CHG_OVERCURRENT: begin
        if (load_on) next_state = cpf_pkg::CPF_NORMAL;
      end
      cpf_pkg::CPF_OVERDISCHARGE: begin
        if (e_od_rel) next_state = cpf_pkg::CPF_NORMAL;
        else if (POWERDOWN_VARIANT && cmp.sense_above_half) next_state = cpf_pkg::CPF_POWERDOWN;
      end
      cpf_pkg::CPF_DSG_OVERCURRENT: begin
        if (!load_on) next_state = cpf_pkg::CPF_NORMAL;
      end
      cpf_pkg::CPF_POWERDOWN: begin
        if (charger_on) next_state = cpf_pkg::CPF_OVERDISCHARGE;
      end
      default: next_state = cpf_pkg::CPF_NORMAL;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) state <= cpf_pkg::CPF_NORMAL;
    else state <= next_state;
  end

  wire chg_on = state == cpf_pkg::CPF_NORMAL || state == cpf_pkg::CPF_OVERDISCHARGE
    || state == cpf_pkg::CPF_DSG_OVERCURRENT || state == cpf_pkg::CPF_POWERDOWN;
  wire dsg_on = state == cpf_pkg::CPF_NORMAL || state == cpf_pkg::CPF_OVERCHARGE
    || state == cpf_pkg::CPF_CHG_OVERCURRENT;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctl_out <= '0;
      state_out <= cpf_pkg::CPF_NORMAL;
    end else begin
      ctl_out.charge_gate_out <= chg_on;
      ctl_out.discharge_gate_out <= dsg_on;
      ctl_out.sense_pullup_en <= state == cpf_pkg::CPF_OVERDISCHARGE
        || state == cpf_pkg::CPF_POWERDOWN;
      ctl_out.sense_pulldown_en <= state == cpf_pkg::CPF_DSG_OVERCURRENT;
      ctl_out.powerdown <= state == cpf_pkg::CPF_POWERDOWN;
      state_out <= state;
    end
  end
endmodule // cpf_top

// >>> hdl/cpf_pkg.sv
// Overview of operation
// - Normal range drives both gates high
// - Sustained overcharge drops charge gate
// - Unlatched: below threshold plus load releases
// - Unlatched: below hysteresis alone releases
// - Latched: below hysteresis plus load releases
// - Sustained overdischarge drops discharge gate
// - Overdischarge enables load-sense pull-up
// - Overdischarge with sense above half enters powerdown
// - Above release level with charger ends overdischarge
// - Sustained discharge overcurrent drops discharge gate
// - Sustained short circuit drops discharge gate
// - Overcurrent or short enables load-sense pull-down
// - Sense at or below 0.25V ends overcurrent
// - Sustained charge overcurrent drops charge gate
// - Load (sense above quarter) alone releases charge overcurrent
// - Charger attach leaves powerdown
// - Powerdown only in enabled variant
// - Sense sign selects charge or discharge checks
// - Test mode shortens overcharge and overdischarge detection delays
package cpf_pkg;
  localparam int CLK_HZ = 40000000;
  // Delays in microseconds, typical figures
  localparam int OVERCHARGE_DETECT_DELAY_US = 1000000;
  localparam int OVERCHARGE_RELEASE_DELAY_US = 2000;
  localparam int OVERDISCHARGE_DETECT_DELAY_US = 128000;
  localparam int OVERDISCHARGE_RELEASE_DELAY_US = 2000;
  localparam int DISCHARGE_OVERCURRENT_DELAY_US = 8000;
  localparam int SHORT_CIRCUIT_DELAY_US = 250;
  localparam int CHARGE_OVERCURRENT_DELAY_US = 8000;
  localparam int TEST_DIVIDE = 64;
  localparam int TIMER_W = 32;
  localparam longint CYC_PER_US = CLK_HZ / 1000000;
  localparam int OC_DET_CYC = int'(OVERCHARGE_DETECT_DELAY_US * CYC_PER_US);
  localparam int OC_REL_CYC = int'(OVERCHARGE_RELEASE_DELAY_US * CYC_PER_US);
  localparam int OD_DET_CYC = int'(OVERDISCHARGE_DETECT_DELAY_US * CYC_PER_US);
  localparam int OD_REL_CYC = int'(OVERDISCHARGE_RELEASE_DELAY_US * CYC_PER_US);
  localparam int DOC_CYC = int'(DISCHARGE_OVERCURRENT_DELAY_US * CYC_PER_US);
  localparam int SC_CYC = int'(SHORT_CIRCUIT_DELAY_US * CYC_PER_US);
  localparam int COC_CYC = int'(CHARGE_OVERCURRENT_DELAY_US * CYC_PER_US);

  typedef enum logic [2:0] {
    CPF_NORMAL, CPF_OVERCHARGE, CPF_CHG_OVERCURRENT, CPF_OVERDISCHARGE,
    CPF_DSG_OVERCURRENT, CPF_POWERDOWN
  } cpf_state_e;

  // Comparator results, raw from the analog front end
  typedef struct packed {
    logic above_overcharge;
    logic above_overcharge_less_hys;
    logic below_overdischarge;
    logic above_overdischarge_release;
    logic above_discharge_overcurrent;
    logic above_short_circuit;
    logic below_charge_overcurrent;
    logic sense_above_quarter;
    logic sense_above_half;
    logic sense_at_supply;
  } cpf_cmp_s;

  typedef struct packed {
    logic charge_gate_out;
    logic discharge_gate_out;
    logic sense_pullup_en;
    logic sense_pulldown_en;
    logic powerdown;
  } cpf_out_s;
endpackage

// >>> dv/cpf_asserts.sv
`timescale 1ns/1ps
module cpf_asserts #(
  parameter int OC_DET = 8,
  parameter int OD_DET = 8,
  parameter int SC_DET = 8
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire cpf_pkg::cpf_cmp_s cmp_in,
  input wire cpf_pkg::cpf_out_s ctl_out,
  input wire cpf_pkg::cpf_state_e state_out
);
  // Lengths of unbroken raw comparator runs
  int run_oc;
  int run_od;
  int run_dsg;
  always_ff @(posedge clock) begin
    run_oc <= cmp_in.above_overcharge ? run_oc + 1 : 0;
    run_od <= cmp_in.below_overdischarge ? run_od + 1 : 0;
    run_dsg <= cmp_in.above_discharge_overcurrent ? run_dsg + 1 : 0;
  end
  // Detection floors, shortened while test mode is selected
  int oc_floor;
  int od_floor;
  assign oc_floor = cmp_in.sense_at_supply ? OC_DET / cpf_pkg::TEST_DIVIDE : OC_DET;
  assign od_floor = cmp_in.sense_at_supply ? OD_DET / cpf_pkg::TEST_DIVIDE : OD_DET;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_normal_gates_on: assert property ((state_out == cpf_pkg::CPF_NORMAL) [*3]
    |-> ctl_out.charge_gate_out && ctl_out.discharge_gate_out) else $error("gates off");
  a_overcharge_gate: assert property ((state_out == cpf_pkg::CPF_OVERCHARGE) [*2]
    |-> !ctl_out.charge_gate_out) else $error("charge gate on in overcharge");
  a_od_pullup: assert property ((state_out == cpf_pkg::CPF_OVERDISCHARGE) [*2]
    |-> ctl_out.sense_pullup_en && !ctl_out.discharge_gate_out) else $error("od outputs");
  a_dsg_pulldown: assert property ((state_out == cpf_pkg::CPF_DSG_OVERCURRENT) [*2]
    |-> ctl_out.sense_pulldown_en && !ctl_out.discharge_gate_out) else $error("oc outputs");
  a_coc_gate: assert property ((state_out == cpf_pkg::CPF_CHG_OVERCURRENT) [*2]
    |-> !ctl_out.charge_gate_out) else $error("charge gate on in charge overcurrent");
  a_oc_entry_delay: assert property (state_out == cpf_pkg::CPF_OVERCHARGE &&
    $past(state_out) == cpf_pkg::CPF_NORMAL |-> run_oc >= oc_floor) else $error("early oc");
  a_od_entry_delay: assert property (state_out == cpf_pkg::CPF_OVERDISCHARGE &&
    $past(state_out) == cpf_pkg::CPF_NORMAL |-> run_od >= od_floor) else $error("early od");
  a_dsg_entry_delay: assert property (state_out == cpf_pkg::CPF_DSG_OVERCURRENT &&
    $past(state_out) == cpf_pkg::CPF_NORMAL |-> run_dsg >= SC_DET) else $error("early dsg");
  a_dsg_release: assert property ((state_out == cpf_pkg::CPF_DSG_OVERCURRENT &&
    !cmp_in.sense_above_quarter) [*2] |-> ##[1:6] state_out == cpf_pkg::CPF_NORMAL)
    else $error("overcurrent not released");
  c_powerdown: cover property (ctl_out.powerdown);
  c_oc_entry: cover property (state_out == cpf_pkg::CPF_OVERCHARGE);
  c_dsg_exit: cover property ($fell(state_out == cpf_pkg::CPF_DSG_OVERCURRENT));
endmodule // cpf_asserts
bind cpf_top cpf_asserts #(.OC_DET(OC_DET), .OD_DET(OD_DET), .SC_DET(SC_DET)) i_cpf_asserts (
  .clock(clock), .sys_rst(sys_rst), .cmp_in(cmp_in), .ctl_out(ctl_out), .state_out(state_out));

// >>> dv/cpf_cell_model.sv
`timescale 1ns/1ps
module cpf_cell_model (
  input wire cpf_pkg::cpf_cmp_s req,
  output cpf_pkg::cpf_cmp_s cmp_in
);
  // Cell, charger and load levels as seen by the comparators
  assign cmp_in = req;
endmodule // cpf_cell_model

// >>> dv/cpf_top_test.sv
`timescale 1ns/1ps
module cpf_top_test;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  cpf_pkg::cpf_cmp_s req = 10'h040;
  cpf_pkg::cpf_cmp_s cmp_in;
  cpf_pkg::cpf_out_s ctl_out;
  cpf_pkg::cpf_state_e state_out;
  cpf_pkg::cpf_out_s ctl_out_l;
  cpf_pkg::cpf_state_e state_out_l;
  int bad_count = 0;
  int comparisons = 0;
  always #12.5 clock = ~clock;
  cpf_cell_model i_cpf_cell_model (.req(req), .cmp_in(cmp_in));
  // Short delays keep each scenario to a few dozen cycles
  localparam int FAST = 8;
  localparam bit LATCHED = 1'b1;
  localparam bit NO_POWERDOWN = 1'b0;
  cpf_top #(.OC_DET(FAST), .OC_REL(FAST), .OD_DET(FAST), .OD_REL(FAST), .DOC_DET(FAST),
    .SC_DET(FAST), .COC_DET(FAST)) i_cpf_top (.clock(clock), .sys_rst(sys_rst),
    .cmp_in(cmp_in), .ctl_out(ctl_out), .state_out(state_out));
  // Latching variant without power-down, fed the same cell levels
  cpf_top #(.LATCH_VARIANT(LATCHED), .POWERDOWN_VARIANT(NO_POWERDOWN), .OC_DET(FAST),
    .OC_REL(FAST), .OD_DET(FAST), .OD_REL(FAST), .DOC_DET(FAST), .SC_DET(FAST),
    .COC_DET(FAST)) i_cpf_top_latched (.clock(clock), .sys_rst(sys_rst), .cmp_in(cmp_in),
    .ctl_out(ctl_out_l), .state_out(state_out_l));
  task automatic check(logic [4:0] got, logic [4:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic split(cpf_pkg::cpf_cmp_s c, int n, cpf_pkg::cpf_state_e es, logic [4:0] eo,
    cpf_pkg::cpf_state_e ls, logic [4:0] lo);
    @(negedge clock);
    req = c;
    repeat (n) @(negedge clock);
    check({2'h0, state_out}, {2'h0, es});
    check(ctl_out, eo);
    check({2'h0, state_out_l}, {2'h0, ls});
    check(ctl_out_l, lo);
    $display("test done at %0t, state %h", $time, es);
  endtask
  task automatic step(cpf_pkg::cpf_cmp_s c, int n, cpf_pkg::cpf_state_e es, logic [4:0] eo);
    split(c, n, es, eo, es, eo);
  endtask
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #(25 * 3000);
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (16) @(negedge clock);
    sys_rst = 1'b0;
    step(10'h040, 4, cpf_pkg::CPF_NORMAL, 5'h18);
    step(10'h340, 6, cpf_pkg::CPF_NORMAL, 5'h18);
    step(10'h040, 2, cpf_pkg::CPF_NORMAL, 5'h18);
    step(10'h340, 24, cpf_pkg::CPF_OVERCHARGE, 5'h08);
    split(10'h144, 24, cpf_pkg::CPF_NORMAL, 5'h18, cpf_pkg::CPF_OVERCHARGE, 5'h08);
    step(10'h340, 24, cpf_pkg::CPF_OVERCHARGE, 5'h08);
    split(10'h040, 24, cpf_pkg::CPF_NORMAL, 5'h18, cpf_pkg::CPF_OVERCHARGE, 5'h08);
    step(10'h044, 24, cpf_pkg::CPF_NORMAL, 5'h18);
    step(10'h080, 24, cpf_pkg::CPF_OVERDISCHARGE, 5'h14);
    split(10'h082, 8, cpf_pkg::CPF_POWERDOWN, 5'h15, cpf_pkg::CPF_OVERDISCHARGE, 5'h14);
    step(10'h080, 8, cpf_pkg::CPF_OVERDISCHARGE, 5'h14);
    step(10'h040, 24, cpf_pkg::CPF_NORMAL, 5'h18);
    step(10'h074, 24, cpf_pkg::CPF_DSG_OVERCURRENT, 5'h12);
    step(10'h040, 8, cpf_pkg::CPF_NORMAL, 5'h18);
    step(10'h064, 24, cpf_pkg::CPF_DSG_OVERCURRENT, 5'h12);
    step(10'h040, 8, cpf_pkg::CPF_NORMAL, 5'h18);
    step(10'h048, 24, cpf_pkg::CPF_CHG_OVERCURRENT, 5'h08);
    step(10'h044, 8, cpf_pkg::CPF_NORMAL, 5'h18);
    step(10'h341, 6, cpf_pkg::CPF_OVERCHARGE, 5'h08);
    step(10'h044, 24, cpf_pkg::CPF_NORMAL, 5'h18);
    complete_run();
  end
endmodule // cpf_top_test
